// ### core/elirq_pkg.sv
// Package for the external line interrupt and event controller
package elirq_pkg;
    localparam int ELIRQ_NLINES = 32;
    localparam int ELIRQ_ADDR_W = 5;
    // Register byte offsets
    localparam logic [4:0] ELIRQ_OFS_IRQ_UNMASK = 5'h00;
    localparam logic [4:0] ELIRQ_OFS_EVT_UNMASK = 5'h04;
    localparam logic [4:0] ELIRQ_OFS_RISE_EN = 5'h08;
    localparam logic [4:0] ELIRQ_OFS_FALL_EN = 5'h0C;
    localparam logic [4:0] ELIRQ_OFS_SOFT_TRIG = 5'h10;
    localparam logic [4:0] ELIRQ_OFS_PENDING = 5'h14;
    // Implemented lines: 18:0 and 22:21
    localparam logic [31:0] ELIRQ_LINE_MASK = 32'h0067FFFF;
    localparam logic [31:0] ELIRQ_REG_RESET = 32'h00000000;
    // Fixed internal source line positions
    localparam int ELIRQ_GPIO_LINES = 16;
    localparam int ELIRQ_LINE_VMON = 16;
    localparam int ELIRQ_LINE_RTC_ALARM = 17;
    localparam int ELIRQ_LINE_USB_WAKE = 18;
    localparam int ELIRQ_LINE_RTC_TAMPER = 21;
    localparam int ELIRQ_LINE_RTC_WAKE = 22;

    typedef struct packed {
        logic [31:0] irq_unmask;
        logic [31:0] evt_unmask;
        logic [31:0] rise_en;
        logic [31:0] fall_en;
        logic [31:0] soft_trig;
        logic [31:0] pending;
    } elirq_regs_type;

    typedef struct packed {
        logic vmon;
        logic rtc_alarm;
        logic usb_otg_wakeup;
        logic rtc_tamper;
        logic rtc_wake;
    } elirq_internal_type;

    typedef struct packed {
        logic [ELIRQ_ADDR_W-1:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } elirq_avmm_req_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic readdatavalid;
        logic waitrequest;
    } elirq_avmm_rsp_type;
endpackage

// ### core/elirq_ctrl.sv
// External line interrupt and event controller with Avalon-MM register slave
//
// Functional notes
// - Lines 0..15 come from the selected GPIO pin of the same number.
// - Lines 16,17,18,21,22 take fixed internal sources; others unused.
// - Per-line interrupt unmask bit, 1 passes, reset zero.
// - Per-line event unmask bit, 1 passes, reset zero.
// - Per-line rising-edge trigger enable, reset zero.
// - Triggering is edge detected only, glitches count as edges.
// - Rising edge during a rising-enable register write is ignored; falling edges still trigger.
// - Rising and falling enables are independent; both give either edge.
// - Event triggers do not set the pending flag.
// - Unmasked event drives the core event input.
// - Map: 00,04,08,0C,10,14 byte offsets.
// - Unmasked interrupt edge sets pending; write one clears it.
// - Per-line falling-edge trigger enable at 0x0C, reset zero.
// - Writing one to soft trigger bit reading zero sets pending if interrupt unmasked, raises request.
`timescale 1ns/100ps
module elirq_ctrl
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire elirq_pkg::elirq_avmm_req_type avs_req,
    output elirq_pkg::elirq_avmm_rsp_type avs_rsp,
    // Line sources
    input wire logic [15:0] gpio_line_in,
    input wire elirq_pkg::elirq_internal_type internal_src,
    // Core side
    output logic [31:0] line_irq,
    output logic irq,
    output logic core_event
);
    import elirq_pkg::*;

    typedef struct packed {
        elirq_regs_type regs;
        logic [31:0] sync1;
        logic [31:0] sync2;
        logic [31:0] sync3;
        logic [31:0] line_irq;
        logic irq;
        logic core_event;
        logic [31:0] readdata;
        logic readdatavalid;
        logic waitrequest;
    } elirq_state_type;
    // Waitrequest leaves reset high so the first request is not taken blind
    localparam elirq_state_type STATE_AT_RESET = '{waitrequest: 1'b1, default: '0};

    elirq_state_type state;
    elirq_state_type next_state;
    logic [31:0] raw_lines;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [31:0] rise_edge;
    logic [31:0] fall_edge;
    logic [31:0] hw_trig;
    logic [31:0] sw_trig;
    logic [31:0] clr;
    logic wr_hit;
    logic bus_take;

    // Byte-enable expansion, used for every writable register
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++)
        begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic is_write(input elirq_avmm_req_type r, input logic taken, input logic [4:0] ofs);
        return taken && r.write && (r.address == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Line source assembly
    always_comb
    begin
        raw_lines = 32'h00000000;
        raw_lines[ELIRQ_GPIO_LINES-1:0] = gpio_line_in;
        raw_lines[ELIRQ_LINE_VMON] = internal_src.vmon;
        raw_lines[ELIRQ_LINE_RTC_ALARM] = internal_src.rtc_alarm;
        raw_lines[ELIRQ_LINE_USB_WAKE] = internal_src.usb_otg_wakeup;
        raw_lines[ELIRQ_LINE_RTC_TAMPER] = internal_src.rtc_tamper;
        raw_lines[ELIRQ_LINE_RTC_WAKE] = internal_src.rtc_wake;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_state = state;
        wmask = be_mask(avs_req.byteenable) & ELIRQ_LINE_MASK;
        wval = avs_req.writedata & wmask;
        next_state.sync1 = raw_lines;
        next_state.sync2 = state.sync1;
        next_state.sync3 = state.sync2;
        // Edges on the last two synchronised copies, sync2 and sync3; any pulse is an edge
        rise_edge = state.sync2 & ~state.sync3 & ELIRQ_LINE_MASK;
        fall_edge = ~state.sync2 & state.sync3 & ELIRQ_LINE_MASK;
        // A write lands only on the edge that sees waitrequest low
        bus_take = !state.waitrequest;
        next_state.waitrequest = !((avs_req.read || avs_req.write) && state.waitrequest);
        wr_hit = is_write(avs_req, bus_take, ELIRQ_OFS_RISE_EN);
        // Rising edges are dropped while the enable is being rewritten
        hw_trig = ((wr_hit ? 32'h00000000 : (rise_edge & state.regs.rise_en))
            | (fall_edge & state.regs.fall_en));
        sw_trig = 32'h00000000;
        clr = 32'h00000000;
        next_state.readdatavalid = 1'b0;
        next_state.readdata = 32'h00000000;
        if (is_write(avs_req, bus_take, ELIRQ_OFS_IRQ_UNMASK))
        begin
            next_state.regs.irq_unmask = (state.regs.irq_unmask & ~wmask) | wval;
        end
        if (is_write(avs_req, bus_take, ELIRQ_OFS_EVT_UNMASK))
        begin
            next_state.regs.evt_unmask = (state.regs.evt_unmask & ~wmask) | wval;
        end
        if (wr_hit)
        begin
            next_state.regs.rise_en = (state.regs.rise_en & ~wmask) | wval;
        end
        if (is_write(avs_req, bus_take, ELIRQ_OFS_FALL_EN))
        begin
            next_state.regs.fall_en = (state.regs.fall_en & ~wmask) | wval;
        end
        if (is_write(avs_req, bus_take, ELIRQ_OFS_SOFT_TRIG))
        begin
            sw_trig = wval & ~state.regs.soft_trig;
        end
        if (is_write(avs_req, bus_take, ELIRQ_OFS_PENDING))
        begin
            clr = wval;
        end
        // Soft trigger bit drops when its pending flag is cleared
        next_state.regs.soft_trig = (state.regs.soft_trig | sw_trig) & ~clr;
        // Set wins over a same-cycle clear; event-only lines leave it alone
        next_state.regs.pending = (state.regs.pending & ~clr)
            | ((hw_trig | sw_trig) & state.regs.irq_unmask);
        next_state.line_irq = next_state.regs.pending;
        next_state.irq = |next_state.regs.pending;
        next_state.core_event = |((hw_trig | sw_trig) & state.regs.evt_unmask);
        if (avs_req.read && state.waitrequest)
        begin
            next_state.readdatavalid = 1'b1;
            case (avs_req.address)
                ELIRQ_OFS_IRQ_UNMASK: next_state.readdata = state.regs.irq_unmask;
                ELIRQ_OFS_EVT_UNMASK: next_state.readdata = state.regs.evt_unmask;
                ELIRQ_OFS_RISE_EN: next_state.readdata = state.regs.rise_en;
                ELIRQ_OFS_FALL_EN: next_state.readdata = state.regs.fall_en;
                ELIRQ_OFS_SOFT_TRIG: next_state.readdata = state.regs.soft_trig;
                ELIRQ_OFS_PENDING: next_state.readdata = state.regs.pending;
                default: next_state.readdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= STATE_AT_RESET;
        end
        else
        begin
            state <= next_state;
        end
    end

    // One wait state per access: read data stand when waitrequest drops
    assign avs_rsp.waitrequest = state.waitrequest;
    assign avs_rsp.readdata = state.readdata;
    assign avs_rsp.readdatavalid = state.readdatavalid;
    assign line_irq = state.line_irq;
    assign irq = state.irq;
    assign core_event = state.core_event;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_unmask_reset;
        @(posedge clock) $fell(rst) |-> (state.regs.irq_unmask == 32'h00000000);
    endproperty
    a_unmask_reset: assert property (p_unmask_reset) else $error("irq unmask not zero after reset");

    property p_evt_reset;
        @(posedge clock) $fell(rst) |-> (state.regs.evt_unmask == 32'h00000000 && !core_event);
    endproperty
    a_evt_reset: assert property (p_evt_reset) else $error("event unmask not zero after reset");

    property p_rise_sets;
        @(posedge clock) disable iff (rst)
        (|(rise_edge & state.regs.rise_en & state.regs.irq_unmask) && !wr_hit)
        |=> irq
            && (($past(rise_edge & state.regs.rise_en & state.regs.irq_unmask) & ~state.regs.pending) == 32'h00000000);
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge did not pend");

    property p_rise_write_ignored;
        @(posedge clock) disable iff (rst)
        (wr_hit && rise_edge != 0 && fall_edge == 0 && sw_trig == 0)
        |=> ((state.regs.pending & ~$past(state.regs.pending)) == 32'h00000000);
    endproperty
    a_rise_write_ignored: assert property (p_rise_write_ignored) else $error("edge during write pended");

    property p_fall_sets;
        @(posedge clock) disable iff (rst)
        |(fall_edge & state.regs.fall_en & state.regs.irq_unmask)
        |=> (($past(fall_edge & state.regs.fall_en & state.regs.irq_unmask) & ~state.regs.pending) == 32'h00000000);
    endproperty
    a_fall_sets: assert property (p_fall_sets) else $error("falling edge did not pend");

    property p_event_no_pend;
        @(posedge clock) disable iff (rst)
        (state.regs.irq_unmask == 32'h00000000 && clr == 32'h00000000)
        |=> (state.regs.pending == $past(state.regs.pending));
    endproperty
    a_event_no_pend: assert property (p_event_no_pend) else $error("masked line pended");

    property p_event_out;
        @(posedge clock) disable iff (rst)
        |((hw_trig | sw_trig) & state.regs.evt_unmask) |=> core_event;
    endproperty
    a_event_out: assert property (p_event_out) else $error("event not delivered");

    property p_clear;
        @(posedge clock) disable iff (rst)
        (clr != 0 && ((hw_trig | sw_trig) & state.regs.irq_unmask) == 0)
        |=> ((state.regs.pending & $past(clr)) == 32'h00000000);
    endproperty
    a_clear: assert property (p_clear) else $error("pending not cleared");

    property p_reserved;
        @(posedge clock) disable iff (rst)
        ((state.regs.irq_unmask | state.regs.evt_unmask | state.regs.rise_en | state.regs.fall_en
            | state.regs.soft_trig | state.regs.pending) & ~ELIRQ_LINE_MASK) == 32'h00000000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake and sticky state checks
    property p_wait_one;
        @(posedge clock) disable iff (rst)
        (avs_req.read || avs_req.write) && avs_rsp.waitrequest |=> !avs_rsp.waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("no answer after one wait state");

    property p_wait_back;
        @(posedge clock) disable iff (rst)
        !avs_rsp.waitrequest |=> avs_rsp.waitrequest;
    endproperty
    a_wait_back: assert property (p_wait_back) else $error("waitrequest low two cycles");

    property p_read_answer;
        @(posedge clock) disable iff (rst)
        avs_rsp.readdatavalid
        |-> !avs_rsp.waitrequest && ((avs_rsp.readdata & ~ELIRQ_LINE_MASK) == 32'h00000000);
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("bad read answer");

    property p_write_lands;
        @(posedge clock) disable iff (rst)
        (avs_req.write && !avs_rsp.waitrequest && avs_req.address == ELIRQ_OFS_IRQ_UNMASK && avs_req.byteenable == 4'hF)
        |=> (state.regs.irq_unmask == ($past(avs_req.writedata) & ELIRQ_LINE_MASK));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("unmask write lost");

    property p_write_waits;
        @(posedge clock) disable iff (rst)
        avs_req.write && avs_rsp.waitrequest
        |=> $stable(state.regs.irq_unmask) && $stable(state.regs.evt_unmask) && $stable(state.regs.rise_en)
            && $stable(state.regs.fall_en);
    endproperty
    a_write_waits: assert property (p_write_waits) else $error("write landed in wait state");

    property p_soft_sets;
        @(posedge clock) disable iff (rst)
        |(sw_trig & state.regs.irq_unmask)
        |=> irq && (($past(sw_trig & state.regs.irq_unmask) & ~state.regs.pending) == 32'h00000000);
    endproperty
    a_soft_sets: assert property (p_soft_sets) else $error("soft trigger did not pend");

    property p_soft_holds;
        @(posedge clock) disable iff (rst)
        (state.regs.soft_trig & ~clr) != 32'h00000000
        |=> (($past(state.regs.soft_trig & ~clr) & ~state.regs.soft_trig) == 32'h00000000);
    endproperty
    a_soft_holds: assert property (p_soft_holds) else $error("soft bit dropped early");

    property p_pend_holds;
        @(posedge clock) disable iff (rst)
        (state.regs.pending & ~clr) != 32'h00000000
        |=> (($past(state.regs.pending & ~clr) & ~state.regs.pending) == 32'h00000000);
    endproperty
    a_pend_holds: assert property (p_pend_holds) else $error("pending dropped without clear");

    property p_event_quiet;
        @(posedge clock) disable iff (rst)
        ((hw_trig | sw_trig) & state.regs.evt_unmask) == 32'h00000000 |=> !core_event;
    endproperty
    a_event_quiet: assert property (p_event_quiet) else $error("spurious event");

    property p_irq_level;
        @(posedge clock) disable iff (rst)
        (line_irq == state.regs.pending) && (irq == (|state.regs.pending));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq outputs disagree with pending");
endmodule

// ### testbench/elirq_core_model.sv
// Behavioural model of the core side: sleeps on a wait instruction, wakes on a request
`timescale 1ns/100ps
module elirq_core_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Requests from the controller
    input wire logic irq,
    input wire logic core_event,
    // Sleep command, 1 waits for irq, 2 waits for event
    input wire logic [1:0] sleep_cmd,
    // Wake-ups seen
    output logic [7:0] wake_count
);
    logic [1:0] asleep;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            asleep <= 2'h0;
            wake_count <= 8'h00;
        end
        else if (sleep_cmd != 2'h0)
            asleep <= sleep_cmd;
        else if ((asleep == 2'h1 && irq) || (asleep == 2'h2 && core_event))
        begin
            asleep <= 2'h0;
            wake_count <= wake_count + 8'h01;
        end
    end
endmodule

// ### testbench/elirq_ctrl_tb_top.sv
// Self-checking bench for the external line interrupt and event controller
`timescale 1ns/100ps
module elirq_ctrl_tb_top;
    import elirq_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    elirq_avmm_req_type req = '0;
    elirq_avmm_rsp_type rsp;
    logic [15:0] gpio = 16'h0000;
    elirq_internal_type isrc = '0;
    logic [31:0] line_irq;
    logic irq;
    logic core_event;
    logic [1:0] sleep_cmd = 2'h0;
    logic [7:0] wake_count;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int events = 0;
    int n;
    logic [31:0] d;
    logic [31:0] ln;
    logic [31:0] expq[$];

    elirq_ctrl i_elirq_ctrl (.clock(clock), .rst(rst), .avs_req(req), .avs_rsp(rsp), .gpio_line_in(gpio),
        .internal_src(isrc), .line_irq(line_irq), .irq(irq), .core_event(core_event));
    elirq_core_model i_elirq_core_model (.clock(clock), .rst(rst), .irq(irq), .core_event(core_event),
        .sleep_cmd(sleep_cmd), .wake_count(wake_count));

    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("errors %0d checks %0d", err_count, total_checks);
        if (err_count == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: word got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %0t: flag got %b exp %b", $time, got, exp);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd, input logic [31:0] exp);
        @(posedge clock);
        req.address <= a;
        req.write <= wr;
        req.read <= !wr;
        req.writedata <= wd;
        req.byteenable <= 4'hF;
        if (!wr)
            expq.push_back(exp);
        do @(posedge clock); while (rsp.waitrequest !== 1'b0);
        req.read <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, 32'h0);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, exp);
    endtask

    task automatic pin(input int k, input logic v);
        @(posedge clock);
        gpio[k] <= v;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Event pulses counted mid-cycle, clear of the launching edge
    always @(negedge clock)
    begin
        if (core_event === 1'b1)
            events++;
    end

    // Read data taken at the edge that samples waitrequest low
    always @(posedge clock)
    begin
        if (rsp.readdatavalid === 1'b1 && rsp.waitrequest === 1'b0)
        begin
            if (expq.size() == 0)
                cmp_word(rsp.readdata, 32'hDEADBEEF);
            else
                cmp_word(rsp.readdata, expq.pop_front());
        end
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n = $urandom(32'hB8EE32D2);
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 7; a++)
            rd(5'(a * 4), 32'h0);
        for (int a = 0; a < 4; a++)
        begin
            d = $urandom();
            wr(5'(a * 4), d);
            rd(5'(a * 4), d & ELIRQ_LINE_MASK);
            wr(5'(a * 4), 32'h0);
        end
        wr(5'h18, 32'hFFFFFFFF);
        rd(5'h18, 32'h0);
        n = $urandom_range(15);
        ln = 32'h1 << n;
        wr(ELIRQ_OFS_IRQ_UNMASK, ln);
        wr(ELIRQ_OFS_RISE_EN, ln);
        // Edge reaches the detector on the edge that takes the enable rewrite
        pin(n, 1'b1);
        wr(ELIRQ_OFS_RISE_EN, ln);
        repeat (5) @(posedge clock);
        rd(ELIRQ_OFS_PENDING, 32'h0);
        pin(n, 1'b0);
        repeat (5) @(posedge clock);
        rd(ELIRQ_OFS_PENDING, 32'h0);
        pin(n, 1'b1);
        repeat (5) @(posedge clock);
        cmp_bit(irq, 1'b1);
        rd(ELIRQ_OFS_PENDING, ln);
        wr(ELIRQ_OFS_PENDING, ln);
        repeat (2) @(posedge clock);
        cmp_bit(irq, 1'b0);
        wr(ELIRQ_OFS_FALL_EN, ln);
        pin(n, 1'b0);
        repeat (5) @(posedge clock);
        rd(ELIRQ_OFS_PENDING, ln);
        wr(ELIRQ_OFS_PENDING, ln);
        // Event only: no pending, one pulse wakes the sleeping core
        wr(ELIRQ_OFS_IRQ_UNMASK, 32'h0);
        wr(ELIRQ_OFS_EVT_UNMASK, ln);
        @(posedge clock);
        sleep_cmd <= 2'h2;
        @(posedge clock);
        sleep_cmd <= 2'h0;
        pin(n, 1'b1);
        repeat (5) @(posedge clock);
        cmp_word(32'(events), 32'h1);
        cmp_word(32'(wake_count), 32'h1);
        rd(ELIRQ_OFS_PENDING, 32'h0);
        @(posedge clock);
        sleep_cmd <= 2'h1;
        @(posedge clock);
        sleep_cmd <= 2'h0;
        wr(ELIRQ_OFS_IRQ_UNMASK, ln);
        wr(ELIRQ_OFS_SOFT_TRIG, ln);
        repeat (2) @(posedge clock);
        cmp_bit(irq, 1'b1);
        cmp_word(32'(events), 32'h2);
        cmp_word(32'(wake_count), 32'h2);
        wr(ELIRQ_OFS_SOFT_TRIG, 32'h0);
        rd(ELIRQ_OFS_SOFT_TRIG, ln);
        wr(ELIRQ_OFS_PENDING, ln);
        rd(ELIRQ_OFS_PENDING, 32'h0);
        // Internal source on its fixed line
        wr(ELIRQ_OFS_IRQ_UNMASK, 32'h1 << ELIRQ_LINE_RTC_WAKE);
        wr(ELIRQ_OFS_RISE_EN, 32'h1 << ELIRQ_LINE_RTC_WAKE);
        @(posedge clock);
        isrc.rtc_wake <= 1'b1;
        repeat (5) @(posedge clock);
        cmp_word(line_irq, 32'h1 << ELIRQ_LINE_RTC_WAKE);
        repeat (3) @(posedge clock);
        wrap_up();
    end
endmodule
